// ---- core/rstctl_pkg.sv ----
// constants and types of the chip reset and watchdog controller
package rstctl_pkg;
  // -----------------------------------------------------------
  // register indices (byte address is four times the index)
  // -----------------------------------------------------------
  localparam logic [13:0] option_control_idx = 14'h0094;
  localparam logic [13:0] software_command_idx = 14'h0097;
  localparam logic [13:0] bandgap_comparator_select_idx = 14'h00c2;
  localparam logic [13:0] bandgap_data_idx = 14'h00c3;
  localparam logic [13:0] auxiliary_control_one_idx = 14'h00f8;
  localparam logic [13:0] flash_config_high_byte_idx = 14'h3fff;
  localparam logic [13:0] reset_cause_status_idx = 14'h0100;
  localparam logic [13:0] reset_cause_mask_idx = 14'h0101;
  // -----------------------------------------------------------
  // reset values and field positions
  // -----------------------------------------------------------
  localparam logic [7:0] option_control_rst = 8'hc1;
  localparam logic [7:0] bandgap_comparator_select_rst = 8'h00;
  localparam logic [7:0] auxiliary_control_one_rst = 8'h00;
  localparam logic [15:0] flash_config_word_rst = 16'h0000;
  localparam logic [7:0] software_reset_command = 8'h56;
  localparam int watchdog_prescale_sel_bit = 2;
  localparam int watchdog_clear_bit = 3;
  localparam int low_volt_reset_two_enable_bit = 7;
  localparam int comparator_result_bit = 7;
  localparam int pin_reset_enable_bit = 14;
  localparam int watchdog_reset_enable_bit = 12;
  localparam logic [16:0] watchdog_long_count = 17'h10000;
  localparam logic [16:0] watchdog_short_count = 17'h08000;
  // cause bits: pin, software, watchdog, lvr one, lvr two
  localparam int cause_width = 5;
  localparam int cause_pin = 0;
  localparam int cause_sw = 1;
  localparam int cause_wdt = 2;
  localparam int cause_low_voltage_reset_one = 3;
  localparam int cause_low_voltage_reset_two = 4;
  // -----------------------------------------------------------
  // timing
  // -----------------------------------------------------------
  localparam int clock_khz = 200000;
  localparam int warmup_ms = 20;
  localparam int warmup_cycles = warmup_ms * clock_khz;
  localparam int slow_rc_khz = 80;
  localparam int slow_rc_div = clock_khz / slow_rc_khz;
  localparam int pin_low_ticks = 2;
  typedef enum logic [1:0] {
    st_warmup, st_load, st_run, st_hold
  } seq_state_type;
endpackage : rstctl_pkg

// ---- core/chip_reset_watchdog.sv ----
// chip reset sequencer, watchdog and reset control registers
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module chip_reset_watchdog #(
  parameter int warmup_count = rstctl_pkg::warmup_cycles,
  parameter int slow_div = rstctl_pkg::slow_rc_div
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] flash_config_word,
  input wire logic ext_reset_in_low,
  input wire logic battery_below_low_voltage_reset_one,
  input wire logic comparator_result,
  input wire logic system_clock_tick,
  input wire logic cpu_halted,
  output logic chip_reset,
  output logic comparator_enable,
  output logic [3:0] comparator_divider_select,
  output logic irq
);
  import rstctl_pkg::*;

  // -----------------------------------------------------------
  // helpers
  // -----------------------------------------------------------
  // 111x is undefined, treated like disabled so no false trip
  function automatic logic divider_valid(input logic [3:0] sel);
    divider_valid = (sel != 4'h0) && (sel[3:1] != 3'h7);
  endfunction : divider_valid

  localparam logic [22:0] warmup_last = 23'(warmup_count - 1);
  localparam logic [15:0] slow_last = 16'(slow_div - 1);

  seq_state_type state_q;
  logic [22:0] warm_q;
  logic [15:0] slow_cnt_q;
  logic slow_tick_q;
  logic [15:0] cfg_q;
  logic [7:0] option_q;
  logic [7:0] bgsel_q;
  logic [7:0] auxiliary_control_one_q;
  logic cmp_q;
  logic [1:0] pin_hist_q;
  logic [16:0] wdt_q;
  logic wdt_ovf;
  logic [cause_width-1:0] status_q;
  logic [cause_width-1:0] mask_q;
  logic [cause_width-1:0] cause;
  logic wr_done;
  logic sfr_rst;
  logic [13:0] idx;
  logic pin_trig;
  logic sw_trig;
  logic wdt_trig;
  logic low_voltage_reset_two_trig;
  logic any_level;
  logic wdt_clr;

  assign idx = paddr[15:2];
  assign wr_done = psel && penable && pready && pwrite;
  assign sfr_rst = (state_q != st_run);

  // -----------------------------------------------------------
  // slow rc tick divider
  // -----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_cnt_q <= 16'h0000;
      slow_tick_q <= 1'b0;
    end else begin
      slow_tick_q <= (slow_cnt_q == slow_last);
      if (slow_cnt_q == slow_last) begin
        slow_cnt_q <= 16'h0000;
      end else begin
        slow_cnt_q <= slow_cnt_q + 16'h0001;
      end
    end
  end

  // -----------------------------------------------------------
  // reset sources
  // -----------------------------------------------------------
  // pin sampled on slow ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_hist_q <= 2'h3;
    end else if (slow_tick_q) begin
      pin_hist_q <= {pin_hist_q[0], ext_reset_in_low};
    end
  end

  assign pin_trig = cfg_q[pin_reset_enable_bit] && (pin_hist_q == 2'h0);
  assign sw_trig = wr_done && (idx == software_command_idx) &&
                   (pwdata[7:0] == software_reset_command);
  assign wdt_trig = wdt_ovf && cfg_q[watchdog_reset_enable_bit];
  assign low_voltage_reset_two_trig = bgsel_q[low_volt_reset_two_enable_bit] &&
                     divider_valid(bgsel_q[3:0]) && !cmp_q;
  assign cause = {low_voltage_reset_two_trig, battery_below_low_voltage_reset_one, wdt_trig, sw_trig,
                  pin_trig};
  // pin and lvr one keep the chip held; lvr two (enable cleared in hold) and pulses only start a hold
  assign any_level = pin_trig || battery_below_low_voltage_reset_one || low_voltage_reset_two_trig;

  // -----------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------
  // warm-up hold then config load
  // merged sources, release on slow tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= st_warmup;
      warm_q <= 23'h000000;
    end else begin
      unique case (state_q)
        st_warmup: begin
          if (warm_q == warmup_last) begin
            state_q <= st_load;
          end else begin
            warm_q <= warm_q + 23'h000001;
          end
        end
        st_load: begin
          state_q <= st_hold;
        end
        st_run: begin
          if ((|cause) || battery_below_low_voltage_reset_one) begin
            state_q <= st_hold;
          end
        end
        st_hold: begin
          if (slow_tick_q && !any_level) begin
            state_q <= st_run;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= flash_config_word_rst;
    end else if (state_q == st_load) begin
      cfg_q <= flash_config_word;
    end
  end

  // -----------------------------------------------------------
  // control registers
  // -----------------------------------------------------------
  // defaults forced while chip reset holds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_q <= option_control_rst;
      bgsel_q <= bandgap_comparator_select_rst;
      auxiliary_control_one_q <= auxiliary_control_one_rst;
    end else if (sfr_rst) begin
      option_q <= option_control_rst;
      bgsel_q <= bandgap_comparator_select_rst;
      auxiliary_control_one_q <= auxiliary_control_one_rst;
    end else if (wr_done) begin
      if (idx == option_control_idx) begin
        option_q <= pwdata[7:0];
      end
      if (idx == bandgap_comparator_select_idx) begin
        bgsel_q <= pwdata[7:0];
      end
      // clear bit is a strobe and never stays set
      if (idx == auxiliary_control_one_idx) begin
        auxiliary_control_one_q <= pwdata[7:0] & ~(8'h01 << watchdog_clear_bit);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_q <= 1'b0;
      comparator_enable <= 1'b0;
      comparator_divider_select <= 4'h0;
    end else begin
      cmp_q <= comparator_result;
      // 0000 and 111x leave comparator off
      comparator_enable <= divider_valid(bgsel_q[3:0]);
      comparator_divider_select <= bgsel_q[3:0];
    end
  end

  // -----------------------------------------------------------
  // watchdog
  // -----------------------------------------------------------
  assign wdt_clr = wr_done && (idx == auxiliary_control_one_idx) &&
                   pwdata[watchdog_clear_bit];
  // prescale bit picks the overflow count
  assign wdt_ovf = system_clock_tick && !cpu_halted &&
                   (state_q == st_run) && !wdt_clr &&
                   (wdt_q == (option_q[watchdog_prescale_sel_bit] ?
                    watchdog_short_count : watchdog_long_count) - 17'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_q <= 17'h00000;
    end else if (sfr_rst || wdt_clr || wdt_ovf) begin
      wdt_q <= 17'h00000;
    end else if (system_clock_tick && !cpu_halted) begin
      wdt_q <= wdt_q + 17'h00001;
    end
  end

  // -----------------------------------------------------------
  // reset cause status and interrupt
  // -----------------------------------------------------------
  // a new cause wins over a write-one-to-clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
      mask_q <= '0;
    end else begin
      if (wr_done && (idx == reset_cause_status_idx)) begin
        status_q <= (status_q & ~pwdata[cause_width-1:0]) |
                    (state_q == st_run ? cause : '0);
      end else if (state_q == st_run) begin
        status_q <= status_q | cause;
      end
      if (wr_done && (idx == reset_cause_mask_idx)) begin
        mask_q <= pwdata[cause_width-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
      chip_reset <= 1'b1;
    end else begin
      irq <= |(status_q & mask_q);
      chip_reset <= sfr_rst;
    end
  end

  // -----------------------------------------------------------
  // apb slave, one wait state per access
  // -----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && penable && !pready) begin
        unique case (idx)
          option_control_idx: prdata[7:0] <= option_q;
          software_command_idx: prdata[7:0] <= 8'h00;
          bandgap_comparator_select_idx: prdata[7:0] <= bgsel_q;
          bandgap_data_idx: prdata[comparator_result_bit] <= cmp_q;
          auxiliary_control_one_idx: prdata[7:0] <= auxiliary_control_one_q;
          flash_config_high_byte_idx: prdata[7:0] <= cfg_q[15:8];
          reset_cause_status_idx: prdata[cause_width-1:0] <= status_q;
          reset_cause_mask_idx: prdata[cause_width-1:0] <= mask_q;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // -----------------------------------------------------------
  // checks
  // -----------------------------------------------------------
  sequence sw_write_seq;
    sw_trig && (state_q == st_run);
  endsequence

  sequence held_seq;
    (state_q == st_hold) ##1 chip_reset;
  endsequence

  a_sw_reset_fire: assert property (
    @(posedge pclk) disable iff (!presetn)
    sw_write_seq |=> held_seq)
    else $error("software command did not reset");

  a_wdt_reset_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wdt_ovf && (state_q == st_run)) |=>
    ((state_q == st_hold) == cfg_q[watchdog_reset_enable_bit]) ||
    $past(cause[cause_pin] || cause[cause_sw] || cause[cause_low_voltage_reset_one] ||
          cause[cause_low_voltage_reset_two]))
    else $error("watchdog gate wrong");

  a_wdt_count_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (cpu_halted && !sfr_rst && !wdt_clr) |=> $stable(wdt_q))
    else $error("watchdog moved while halted");

  a_wdt_prescale_top: assert property (
    @(posedge pclk) disable iff (!presetn)
    option_q[watchdog_prescale_sel_bit] |-> wdt_q < watchdog_short_count)
    else $error("watchdog passed short limit");

  a_wdt_clear_now: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wdt_clr || sfr_rst) |=> (wdt_q == 17'h00000))
    else $error("watchdog not cleared");

  a_low_voltage_reset_one_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    battery_below_low_voltage_reset_one [*3] |-> chip_reset)
    else $error("low battery did not hold reset");

  a_low_voltage_reset_two_gated: assert property (
    @(posedge pclk) disable iff (!presetn)
    !bgsel_q[low_volt_reset_two_enable_bit] |-> !low_voltage_reset_two_trig)
    else $error("second low-voltage reset fired disabled");

  a_pin_gated: assert property (
    @(posedge pclk) disable iff (!presetn)
    pin_trig |-> cfg_q[pin_reset_enable_bit] && !pin_hist_q[1])
    else $error("pin reset acted while disabled");

  a_cfg_kept: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_q != st_load) |=> $stable(cfg_q))
    else $error("config word changed outside load");

  a_release_slow: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(chip_reset) |-> $past(slow_tick_q, 2))
    else $error("reset released off slow tick");

  a_sfr_defaults: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_q == st_hold) ##1 (state_q == st_hold) |->
    (option_q == option_control_rst) && (bgsel_q == 8'h00))
    else $error("registers not at defaults in reset");

  a_divider_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    (bgsel_q[3:0] == 4'h0) [*2] |-> !comparator_enable)
    else $error("comparator on with divider 0000");

  a_cmp_readback: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready && (idx == bandgap_data_idx)) |=>
    (prdata[comparator_result_bit] == $past(cmp_q)))
    else $error("comparator result read wrong");
endmodule : chip_reset_watchdog

// ---- testbench/pin_cmp_partner.sv ----
// far-side model: external reset pin driver and bandgap comparator
`timescale 1ns/1ps
module pin_cmp_partner #(
  parameter int slow_div = 8
) (
  input wire logic pclk,
  input wire logic pin_req,
  input wire logic cmp_high,
  output logic ext_reset_in_low,
  output logic comparator_result
);
  int low_cnt = 0;
  // ---------------------------------------------------------------
  // pin driver
  // ---------------------------------------------------------------
  // low for three slow periods
  // three periods, not two, so tick phase cannot shorten the pulse
  always @(posedge pclk) begin
    if (pin_req && low_cnt == 0) begin
      low_cnt <= 3 * slow_div;
    end else if (low_cnt > 0) begin
      low_cnt <= low_cnt - 1;
    end
  end
  // pin has a pull-up, so it idles high when released
  assign ext_reset_in_low = (low_cnt == 0);
  // ---------------------------------------------------------------
  // comparator
  // ---------------------------------------------------------------
  // high while divided battery above reference
  assign comparator_result = cmp_high;
endmodule : pin_cmp_partner

// ---- testbench/chip_reset_watchdog_tb.sv ----
// self-checking bench of the chip reset and watchdog controller
`timescale 1ns/1ps
module chip_reset_watchdog_tb;
  import rstctl_pkg::*;
  localparam int sdiv = 8;
  localparam int warm = 50;
  logic pclk = 1'b0;
  // starts high so the first drive low is a real falling edge
  logic presetn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] cfg = 16'h5000;
  logic low_voltage_reset_one = 1'b0;
  logic tick = 1'b0;
  logic halted = 1'b0;
  logic pin_req = 1'b0;
  logic cmp_high = 1'b1;
  logic pin_n;
  logic cmp_res;
  logic chip_reset;
  logic cmp_en;
  logic irq;
  logic [3:0] div_sel;
  logic [31:0] rng = 32'd23918;
  logic [31:0] rd;
  logic [31:0] v;
  logic err;
  logic bad;
  logic [7:0] exp_opt;
  logic [7:0] exp_aux;
  int error_cnt = 0;
  int num_checks = 0;
  int wcnt = 0;

  always #2.5 pclk = ~pclk;

  chip_reset_watchdog #(.warmup_count(warm), .slow_div(sdiv)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_config_word(cfg),
    .ext_reset_in_low(pin_n), .battery_below_low_voltage_reset_one(low_voltage_reset_one),
    .comparator_result(cmp_res), .system_clock_tick(tick),
    .cpu_halted(halted), .chip_reset(chip_reset),
    .comparator_enable(cmp_en), .comparator_divider_select(div_sel),
    .irq(irq));

  pin_cmp_partner #(.slow_div(sdiv)) far_u (
    .pclk(pclk), .pin_req(pin_req), .cmp_high(cmp_high),
    .ext_reset_in_low(pin_n), .comparator_result(cmp_res));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs

  task automatic end_sim();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // request held until pready is seen high at a rising edge
  task automatic bus(input logic w, input logic [13:0] idx,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the bench watchdog ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus

  task automatic rdchk(input logic [13:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task automatic wait_rst(input logic lvl, input int lim);
    int n;
    n = 0;
    while (chip_reset !== lvl && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, chip_reset}, {31'h0, lvl});
  endtask : wait_rst

  task automatic quiet(input int n);
    bad = 1'b0;
    repeat (n) begin
      @(posedge pclk);
      if (chip_reset !== 1'b0) bad = 1'b1;
    end
    chk({31'h0, bad}, 32'h0);
  endtask : quiet

  task automatic por();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (warm) @(posedge pclk);
    chk({31'h0, chip_reset}, 32'h1);
    wait_rst(1'b0, 200);
  endtask : por

  // ticks with random halts, counted only while running
  task automatic wd_run(input int target);
    while (wcnt < target) begin
      v = xs();
      tick <= 1'b1;
      halted <= v[0] & v[1];
      @(posedge pclk);
      if (tick && !halted) wcnt++;
      if (chip_reset !== 1'b0) bad = 1'b1;
    end
    tick <= 1'b0;
  endtask : wd_run

  initial begin
    #400us;
    error_cnt++;
    end_sim();
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    por();
    rdchk(flash_config_high_byte_idx, 32'h50);
    rdchk(option_control_idx, 32'hc1);
    rdchk(bandgap_comparator_select_idx, 32'h0);
    rdchk(auxiliary_control_one_idx, 32'h0);
    rdchk(software_command_idx, 32'h0);
    rdchk(14'h0010, 32'h0);
    chk({31'h0, err}, 32'h1);
    v = xs();
    exp_opt = v[7:0];
    exp_aux = v[15:8] & 8'hf7;
    bus(1'b1, option_control_idx, {24'h0, exp_opt});
    bus(1'b1, auxiliary_control_one_idx, {24'h0, v[15:8]});
    rdchk(option_control_idx, {24'h0, exp_opt});
    rdchk(auxiliary_control_one_idx, {24'h0, exp_aux});
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, bandgap_comparator_select_idx, 32'(c));
      rdchk(bandgap_comparator_select_idx, 32'(c));
      chk({31'h0, cmp_en}, 32'(c != 0 && c < 14));
      chk({28'h0, div_sel}, 32'(c));
    end
    bus(1'b1, bandgap_comparator_select_idx, 32'h03);
    cmp_high <= 1'b0;
    quiet(20);
    rdchk(bandgap_data_idx, 32'h0);
    cmp_high <= 1'b1;
    rdchk(bandgap_data_idx, 32'h80);
    bus(1'b1, bandgap_comparator_select_idx, 32'h83);
    quiet(10);
    cmp_high <= 1'b0;
    wait_rst(1'b1, 10);
    cmp_high <= 1'b1;
    wait_rst(1'b0, 40);
    rdchk(bandgap_comparator_select_idx, 32'h0);
    // only 56h resets; config input changed, not reloaded
    cfg <= 16'h0000;
    bus(1'b1, option_control_idx, 32'hc5);
    bus(1'b1, software_command_idx, 32'h55);
    quiet(10);
    bus(1'b1, software_command_idx, 32'h56);
    wait_rst(1'b1, 5);
    wait_rst(1'b0, 40);
    rdchk(option_control_idx, 32'hc1);
    rdchk(flash_config_high_byte_idx, 32'h50);
    bus(1'b0, reset_cause_status_idx, 32'h0);
    chk(rd & 32'h2, 32'h2);
    bus(1'b1, reset_cause_mask_idx, 32'h2);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, reset_cause_status_idx, 32'h1f);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    @(posedge pclk);
    pin_req <= 1'b1;
    @(posedge pclk);
    pin_req <= 1'b0;
    wait_rst(1'b1, 40);
    wait_rst(1'b0, 60);
    low_voltage_reset_one <= 1'b1;
    wait_rst(1'b1, 5);
    bad = 1'b0;
    repeat (30) begin
      @(posedge pclk);
      if (chip_reset !== 1'b1) bad = 1'b1;
    end
    chk({31'h0, bad}, 32'h0);
    low_voltage_reset_one <= 1'b0;
    wait_rst(1'b0, 40);
    // short overflow, cleared midway, halts hold count
    bus(1'b1, option_control_idx, 32'hc5);
    bad = 1'b0;
    wcnt = 0;
    wd_run(8000);
    bus(1'b1, auxiliary_control_one_idx, 32'h08);
    wcnt = 0;
    // one tick short of the limit must not trip
    wd_run(32767);
    quiet(3);
    wd_run(32768);
    chk({31'h0, bad}, 32'h0);
    wait_rst(1'b1, 10);
    wait_rst(1'b0, 60);
    // pin ignored when enable bit clear
    cfg <= 16'h1000;
    por();
    rdchk(flash_config_high_byte_idx, 32'h10);
    @(posedge pclk);
    pin_req <= 1'b1;
    @(posedge pclk);
    pin_req <= 1'b0;
    quiet(40);
    end_sim();
  end
endmodule : chip_reset_watchdog_tb
